// ==== common/amem_defs.svh ====
// Constants for the asynchronous memory strobe and wait sequencer.
`ifndef AMEM_DEFS_SVH
`define AMEM_DEFS_SVH

// Pin widths of the external memory port.
`define AMEM_ADDR_W 20
`define AMEM_BANK_W 2
`define AMEM_BE_W 8
`define AMEM_DATA_W 64

// Number of chip-select regions and the width of their index.
`define AMEM_REGIONS 4
`define AMEM_REGION_W 2

// Default widths of the programmed phase counts.
`define AMEM_SETUP_W 4
`define AMEM_STROBE_W 6
`define AMEM_HOLD_W 3

// Width of the phase down-counter.
`define AMEM_CNT_W 8

// Divider from clk to the internal interface clock source.
`define AMEM_SYS_CLOCK_DIV 4
`define AMEM_DIV_W 2

// Byte offset of the wait-cycle configuration register in the map.
`define AMEM_WAIT_CYCLE_CONFIG_OFFSET 32'h700000a0

// Reset value of the ready polarity: ready is active high.
`define AMEM_READY_POLARITY_RST 1'b1

`endif

// ==== common/amem_pkg.sv ====
// Types shared by the asynchronous memory sequencer.
`default_nettype none
package amem_pkg;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_SETUP  = 2'b01,
        PH_STROBE = 2'b10,
        PH_HOLD   = 2'b11
    } phase_e;

endpackage
`default_nettype wire

// ==== design/async_memory_strobe_wait_ctrl.sv ====
// Asynchronous memory access sequencer with setup, strobe, hold and ready waits.
//
// Contract
// [R1] Interface clock is external input or internal source; forwarded clock matches it.
// [R2] Read and write setup, strobe, hold counts are programmed per region.
// [R3] Read select signals stand valid for read setup cycles before output enable.
// [R4] Write selects, direction and data stand valid write setup cycles first.
// [R5] After write enable rises, selects and data stay stable for write hold cycles.
// [R6] Selects are chip select, byte enables, address, bank; writes add direction, data.
// [R7] Shared enable pins act as asynchronous output and write enables.
// [R8] Ready polarity is programmable and ready is read by that setting.
// [R9] Not-ready seen two periods before strobe end stretches the strobe.
// [R10] Ready sampled on falling edges; hold starts within four periods.
// [R11] Ready passes an internal synchronizer; memory holds levels two periods.
// [R12] Memory keeps each ready level at least two periods plus five nanoseconds.
// [R13] Software programs read strobe long enough for memory access time.
// [R14] Wait-cycle configuration holding ready polarity sits at its own offset.
// [R15] Access walks setup, strobe with waits, hold; edges align to rising clock.
// [R16] Read data is captured at strobe end, just before output enable rises.
`timescale 1ns/1ps
`default_nettype none
`include "amem_defs.svh"
module async_memory_strobe_wait_ctrl #(
    parameter int REGIONS  = `AMEM_REGIONS,
    parameter int SETUP_W  = `AMEM_SETUP_W,
    parameter int STROBE_W = `AMEM_STROBE_W,
    parameter int HOLD_W   = `AMEM_HOLD_W
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    input  wire logic                                   ext_clock_in,
    input  wire logic                                   clock_source_sel,
    input  wire logic                                   ready_polarity,
    input  wire logic [REGIONS-1:0][SETUP_W-1:0]        read_setup_cycles,
    input  wire logic [REGIONS-1:0][STROBE_W-1:0]       read_strobe_cycles,
    input  wire logic [REGIONS-1:0][HOLD_W-1:0]         read_hold_cycles,
    input  wire logic [REGIONS-1:0][SETUP_W-1:0]        write_setup_cycles,
    input  wire logic [REGIONS-1:0][STROBE_W-1:0]       write_strobe_cycles,
    input  wire logic [REGIONS-1:0][HOLD_W-1:0]         write_hold_cycles,
    input  wire logic                                   req_valid,
    input  wire logic                                   req_write,
    input  wire logic [`AMEM_REGION_W-1:0]              req_region,
    input  wire logic [`AMEM_ADDR_W-1:0]                req_addr,
    input  wire logic [`AMEM_BANK_W-1:0]                req_bank,
    input  wire logic [`AMEM_BE_W-1:0]                  req_be_n,
    input  wire logic [`AMEM_DATA_W-1:0]                req_wdata,
    output logic                                        req_ready,
    output logic                                        rsp_valid,
    output logic [`AMEM_DATA_W-1:0]                     rsp_rdata,
    output logic                                        mem_clock_out,
    output logic [REGIONS-1:0]                          chip_select_n,
    output logic [`AMEM_BE_W-1:0]                       byte_enable_n,
    output logic [`AMEM_ADDR_W-1:0]                     ext_address,
    output logic [`AMEM_BANK_W-1:0]                     bank_address,
    output logic                                        read_write_dir,
    input  wire logic [`AMEM_DATA_W-1:0]                ext_data_in,
    output logic [`AMEM_DATA_W-1:0]                     ext_data_out,
    output logic                                        ext_data_oe,
    output logic                                        async_output_enable_n,
    output logic                                        async_write_enable_n,
    input  wire logic                                   async_ready_in
);

    // Request side, running on clk.
    typedef struct packed {
        logic [`AMEM_DIV_W-1:0]    div;
        logic                      div_clk;
        logic                      wait_pol;
        logic                      busy;
        logic                      ready;
        logic                      req_tgl;
        logic                      ack_meta;
        logic                      ack_sync;
        logic                      ack_seen;
        logic                      rsp;
        logic [`AMEM_DATA_W-1:0]   rdata;
        logic                      wr;
        logic [`AMEM_REGION_W-1:0] region;
        logic [`AMEM_ADDR_W-1:0]   addr;
        logic [`AMEM_BANK_W-1:0]   bank;
        logic [`AMEM_BE_W-1:0]     be_n;
        logic [`AMEM_DATA_W-1:0]   wdata;
        logic [SETUP_W-1:0]        setup;
        logic [STROBE_W-1:0]       strobe;
        logic [HOLD_W-1:0]         hold;
        logic                      pol;
    } sys_s;

    // Link side, running on the interface clock.
    typedef struct packed {
        logic                      rst_meta;
        logic                      rst_sync;
        logic                      req_meta;
        logic                      req_sync;
        logic                      req_seen;
        logic                      ack_tgl;
        amem_pkg::phase_e          phase;
        logic [`AMEM_CNT_W-1:0]    cnt;
        logic                      wr;
        logic [REGIONS-1:0]        cs_n;
        logic [`AMEM_BE_W-1:0]     be_n;
        logic [`AMEM_ADDR_W-1:0]   addr;
        logic [`AMEM_BANK_W-1:0]   bank;
        logic                      dir;
        logic [`AMEM_DATA_W-1:0]   dout;
        logic                      doe;
        logic                      oe_n;
        logic                      we_n;
        logic [`AMEM_DATA_W-1:0]   rdata;
    } link_s;

    sys_s  s_r;
    sys_s  s_nxt;
    link_s l_r;
    link_s l_nxt;
    logic  if_clk;
    logic  ready_synced;
    logic  ready_ok;

    // Turns a programmed count into a down-counter load; zero counts as one cycle.
    function automatic logic [`AMEM_CNT_W-1:0] cyc_load(input logic [`AMEM_CNT_W-1:0] n);
        cyc_load = (n == '0) ? '0 : n - `AMEM_CNT_W'(1);
    endfunction

    // Interface clock: external input or clk divided down; the select is not gated and switches it busy or idle.
    assign if_clk        = clock_source_sel ? s_r.div_clk : ext_clock_in; // [R1]
    assign mem_clock_out = if_clk; // [R1]

    always_comb begin
        s_nxt = s_r;
        s_nxt.div = s_r.div + `AMEM_DIV_W'(1);
        s_nxt.div_clk = s_r.div[`AMEM_DIV_W-1];
        s_nxt.wait_pol = ready_polarity; // [R14]
        s_nxt.ack_meta = l_r.ack_tgl;
        s_nxt.ack_sync = s_r.ack_meta;
        s_nxt.rsp = 1'b0;
        if (s_r.ack_sync != s_r.ack_seen) begin
            s_nxt.ack_seen = s_r.ack_sync;
            s_nxt.busy = 1'b0;
            s_nxt.ready = 1'b1;
            s_nxt.rsp = 1'b1;
            s_nxt.rdata = l_r.rdata;
        end else if (!s_r.busy && req_valid) begin
            s_nxt.busy = 1'b1;
            s_nxt.ready = 1'b0;
            s_nxt.req_tgl = ~s_r.req_tgl;
            s_nxt.wr = req_write;
            s_nxt.region = req_region;
            s_nxt.addr = req_addr;
            s_nxt.bank = req_bank;
            s_nxt.be_n = req_be_n;
            s_nxt.wdata = req_wdata;
            s_nxt.pol = s_r.wait_pol; // [R8]
            if (req_write) begin
                s_nxt.setup = write_setup_cycles[req_region]; // [R2]
                s_nxt.strobe = write_strobe_cycles[req_region]; // [R2]
                s_nxt.hold = write_hold_cycles[req_region]; // [R2]
            end else begin
                s_nxt.setup = read_setup_cycles[req_region]; // [R2]
                s_nxt.strobe = read_strobe_cycles[req_region]; // [R2]
                s_nxt.hold = read_hold_cycles[req_region]; // [R2]
            end
        end
        if (!rst_n) begin
            s_nxt = '0;
            s_nxt.ready = 1'b1;
            s_nxt.wait_pol = `AMEM_READY_POLARITY_RST;
            s_nxt.pol = `AMEM_READY_POLARITY_RST;
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    ready_sync u_ready_sync (
        .if_clk (if_clk),
        .din    (async_ready_in),
        .dout   (ready_synced)
    );

    // Ready is the synchronized pin compared against the captured polarity.
    assign ready_ok = ready_synced ~^ s_r.pol; // [R8]

    always_comb begin
        l_nxt = l_r;
        l_nxt.rst_meta = rst_n;
        l_nxt.rst_sync = l_r.rst_meta;
        l_nxt.req_meta = s_r.req_tgl;
        l_nxt.req_sync = l_r.req_meta;
        unique case (l_r.phase)
            amem_pkg::PH_IDLE: begin
                if (l_r.req_sync != l_r.req_seen) begin
                    l_nxt.req_seen = l_r.req_sync;
                    l_nxt.wr = s_r.wr;
                    l_nxt.cs_n = '1;
                    l_nxt.cs_n[s_r.region] = 1'b0; // [R6]
                    l_nxt.be_n = s_r.be_n; // [R6]
                    l_nxt.addr = s_r.addr; // [R6]
                    l_nxt.bank = s_r.bank; // [R6]
                    l_nxt.dir = ~s_r.wr; // [R4]
                    l_nxt.dout = s_r.wdata; // [R4]
                    l_nxt.doe = s_r.wr; // [R4]
                    l_nxt.cnt = cyc_load(`AMEM_CNT_W'(s_r.setup)); // [R3]
                    l_nxt.phase = amem_pkg::PH_SETUP; // [R15]
                end
            end
            amem_pkg::PH_SETUP: begin
                if (l_r.cnt != '0) begin
                    l_nxt.cnt = l_r.cnt - `AMEM_CNT_W'(1);
                end else begin
                    l_nxt.oe_n = l_r.wr; // [R3]
                    l_nxt.we_n = ~l_r.wr; // [R4]
                    l_nxt.cnt = cyc_load(`AMEM_CNT_W'(s_r.strobe));
                    l_nxt.phase = amem_pkg::PH_STROBE; // [R15]
                end
            end
            amem_pkg::PH_STROBE: begin
                if (l_r.cnt != '0) begin
                    l_nxt.cnt = l_r.cnt - `AMEM_CNT_W'(1);
                end else if (ready_ok) begin // [R9]
                    l_nxt.oe_n = 1'b1; // [R7]
                    l_nxt.we_n = 1'b1; // [R7]
                    if (!l_r.wr) begin
                        l_nxt.rdata = ext_data_in; // [R16]
                    end
                    l_nxt.cnt = cyc_load(`AMEM_CNT_W'(s_r.hold));
                    l_nxt.phase = amem_pkg::PH_HOLD; // [R10]
                end
            end
            amem_pkg::PH_HOLD: begin
                if (l_r.cnt != '0) begin
                    l_nxt.cnt = l_r.cnt - `AMEM_CNT_W'(1); // [R5]
                end else begin
                    l_nxt.cs_n = '1;
                    l_nxt.doe = 1'b0;
                    l_nxt.dir = 1'b1;
                    l_nxt.ack_tgl = ~l_r.ack_tgl;
                    l_nxt.phase = amem_pkg::PH_IDLE; // [R15]
                end
            end
        endcase
        if (!l_r.rst_sync) begin
            l_nxt = '0;
            l_nxt.rst_meta = rst_n;
            l_nxt.rst_sync = l_r.rst_meta;
            l_nxt.req_meta = s_r.req_tgl;
            l_nxt.req_sync = l_r.req_meta;
            l_nxt.req_seen = l_r.req_sync;
            l_nxt.phase = amem_pkg::PH_IDLE;
            l_nxt.cs_n = '1;
            l_nxt.be_n = '1;
            l_nxt.dir = 1'b1;
            l_nxt.oe_n = 1'b1;
            l_nxt.we_n = 1'b1;
        end
    end

    always_ff @(posedge if_clk) begin // [R15]
        l_r <= l_nxt;
    end

    assign req_ready             = s_r.ready;
    assign rsp_valid             = s_r.rsp;
    assign rsp_rdata             = s_r.rdata;
    assign chip_select_n         = l_r.cs_n;
    assign byte_enable_n         = l_r.be_n;
    assign ext_address           = l_r.addr;
    assign bank_address          = l_r.bank;
    assign read_write_dir        = l_r.dir;
    assign ext_data_out          = l_r.dout;
    assign ext_data_oe           = l_r.doe;
    assign async_output_enable_n = l_r.oe_n; // [R7]
    assign async_write_enable_n  = l_r.we_n; // [R7]

endmodule
`default_nettype wire

// ==== design/ready_sync.sv ====
// Two-stage synchronizer for the ready pin, clocked on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module ready_sync (
    input  wire logic if_clk,
    input  wire logic din,
    output logic      dout
);

    typedef struct packed {
        logic meta;
        logic sync;
    } sync_s;

    sync_s q_r;
    sync_s q_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        q_nxt      = q_r;
        q_nxt.meta = din;
        q_nxt.sync = q_r.meta;
    end

    always_ff @(negedge if_clk) begin // [R10]
        q_r <= q_nxt; // [R11]
    end

    assign dout = q_r.sync;

endmodule
`default_nettype wire

// ==== tb/amem_mem_model.sv ====
// Behavioural asynchronous memory on the far side of the sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "amem_defs.svh"
module amem_mem_model (
    input  wire logic [3:0]              chip_select_n,
    input  wire logic                    mem_clock_out,
    input  wire logic [`AMEM_ADDR_W-1:0] ext_address,
    input  wire logic [`AMEM_DATA_W-1:0] ext_data_out,
    input  wire logic                    async_output_enable_n,
    input  wire logic                    async_write_enable_n,
    input  wire logic                    ready_polarity,
    input  wire logic                    stall,
    output logic [`AMEM_DATA_W-1:0]      ext_data_in,
    output logic                         async_ready_in,
    output logic [`AMEM_ADDR_W-1:0]      wr_addr,
    output logic [`AMEM_DATA_W-1:0]      wr_data
);
    logic [`AMEM_DATA_W-1:0] junk_r = 64'h0;
    logic                    rdy_r  = 1'b1;

    assign async_ready_in = rdy_r;

    // Ready moves only on rising edges, far from the falling sampling edge.
    always @(posedge mem_clock_out) begin
        junk_r <= ~junk_r ^ {44'h0, ext_address};
        rdy_r  <= stall ? ~ready_polarity : ready_polarity;
    end

    // Zero access time; the strobe width covers it.
    assign ext_data_in = (!async_output_enable_n && !(&chip_select_n)) ?
        {ext_address, ext_address, ext_address, 4'ha} : junk_r;

    always @(posedge async_write_enable_n) begin
        if (!(&chip_select_n)) begin
            wr_addr <= ext_address;
            wr_data <= ext_data_out;
        end
    end
endmodule
`default_nettype wire

// ==== tb/amem_props.sv ====
// Port checker for the asynchronous memory sequencer, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "amem_defs.svh"
module amem_props #(
    parameter int REGIONS  = `AMEM_REGIONS,
    parameter int SETUP_W  = `AMEM_SETUP_W,
    parameter int STROBE_W = `AMEM_STROBE_W,
    parameter int HOLD_W   = `AMEM_HOLD_W
) (
    input wire logic                              clk,
    input wire logic                              rst_n,
    input wire logic                              req_valid,
    input wire logic                              req_ready,
    input wire logic                              rsp_valid,
    input wire logic                              mem_clock_out,
    input wire logic [REGIONS-1:0]                chip_select_n,
    input wire logic                              read_write_dir,
    input wire logic                              ext_data_oe,
    input wire logic [`AMEM_ADDR_W-1:0]           ext_address,
    input wire logic [`AMEM_DATA_W-1:0]           ext_data_out,
    input wire logic                              async_output_enable_n,
    input wire logic                              async_write_enable_n,
    input wire logic [REGIONS-1:0][SETUP_W-1:0]   read_setup_cycles,
    input wire logic [REGIONS-1:0][SETUP_W-1:0]   write_setup_cycles,
    input wire logic [REGIONS-1:0][HOLD_W-1:0]    write_hold_cycles
);
    logic                      idle;
    logic [7:0]                age_r;
    logic [7:0]                rel_r;
    logic [`AMEM_REGION_W-1:0] reg_r;

    function automatic int eff(input int x);
        return (x == 0) ? 1 : x;
    endfunction

    assign idle = &chip_select_n;

    // Edges since the selects went active, edges since the write strobe rose, active region.
    always_ff @(posedge mem_clock_out) begin
        age_r <= (!rst_n || idle) ? 8'h00 : age_r + 8'h01;
        rel_r <= (!rst_n || !async_write_enable_n) ? 8'h00 : rel_r + 8'h01;
        for (int i = 0; i < REGIONS; i++) begin
            if (!chip_select_n[i]) begin
                reg_r <= `AMEM_REGION_W'(i);
            end
        end
    end

    chk_single_select: assert property (@(posedge clk) disable iff (!rst_n)
        $countones(~chip_select_n) <= 1) else $error("two chip selects active");
    chk_read_strobe_sel: assert property (@(posedge clk) disable iff (!rst_n)
        !async_output_enable_n |-> !idle && read_write_dir && !ext_data_oe)
        else $error("read strobe without read selects");
    chk_write_strobe_sel: assert property (@(posedge clk) disable iff (!rst_n)
        !async_write_enable_n |-> !idle && !read_write_dir && ext_data_oe)
        else $error("write strobe without write selects");
    chk_read_setup_len: assert property (@(posedge mem_clock_out) disable iff (!rst_n)
        $fell(async_output_enable_n) |-> age_r == eff(read_setup_cycles[reg_r]))
        else $error("read setup length wrong");
    chk_write_setup_len: assert property (@(posedge mem_clock_out) disable iff (!rst_n)
        $fell(async_write_enable_n) |-> age_r == eff(write_setup_cycles[reg_r]))
        else $error("write setup length wrong");
    // The enable starts unknown before the link reset, so a fall is only taken from a known high.
    chk_write_hold_len: assert property (@(posedge mem_clock_out) disable iff (!rst_n)
        $past(ext_data_oe) && !ext_data_oe |-> idle && rel_r == eff(write_hold_cycles[reg_r]))
        else $error("write hold length wrong");
    chk_write_sel_stable: assert property (@(posedge mem_clock_out) disable iff (!rst_n)
        ext_data_oe && $past(ext_data_oe) |-> $stable(ext_address) && $stable(ext_data_out)
        && $stable(chip_select_n)) else $error("write selects moved");
    chk_one_access: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && req_ready |=> !req_ready) else $error("request taken while busy");
    chk_rsp_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        rsp_valid |=> !rsp_valid) else $error("completion longer than one cycle");
endmodule
bind async_memory_strobe_wait_ctrl amem_props #(.REGIONS(REGIONS), .SETUP_W(SETUP_W),
    .STROBE_W(STROBE_W), .HOLD_W(HOLD_W)) amem_props_i (.clk, .rst_n, .req_valid,
    .req_ready, .rsp_valid, .mem_clock_out, .chip_select_n, .read_write_dir, .ext_data_oe,
    .ext_address, .ext_data_out, .async_output_enable_n, .async_write_enable_n,
    .read_setup_cycles, .write_setup_cycles, .write_hold_cycles);
`default_nettype wire

// ==== tb/test_async_memory_strobe_wait_ctrl.sv ====
// Self-checking testbench for the asynchronous memory sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_async_memory_strobe_wait_ctrl;
    logic clk = 0, rst_n = 0, ext_clock_in = 0, src_sel = 0, pol = 1, stall = 0;
    logic req_valid = 0, req_write = 0, req_ready, rsp_valid, mck, dir, doe, oe_n, we_n, rdy;
    logic [1:0] req_region = 0, req_bank = 0, bank;
    logic [19:0] req_addr = 0, addr, wr_addr;
    logic [7:0] req_be_n = 8'hff, be_n;
    logic [63:0] req_wdata = 0, rsp_rdata, din, dout, wr_data;
    logic [3:0] cs_n;
    logic [3:0][3:0] rs, ws;
    logic [3:0][5:0] rt, wt;
    logic [3:0][2:0] rh, wh;
    int err_total = 0;
    int checked = 0;

    always #2 clk = ~clk;
    initial begin
        #37;
        forever #80 ext_clock_in = ~ext_clock_in;
    end

    async_memory_strobe_wait_ctrl async_memory_strobe_wait_ctrl_i (.clk, .rst_n, .ext_clock_in,
        .clock_source_sel(src_sel), .ready_polarity(pol), .read_setup_cycles(rs),
        .read_strobe_cycles(rt), .read_hold_cycles(rh), .write_setup_cycles(ws),
        .write_strobe_cycles(wt), .write_hold_cycles(wh), .req_valid, .req_write, .req_region,
        .req_addr, .req_bank, .req_be_n, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
        .mem_clock_out(mck), .chip_select_n(cs_n), .byte_enable_n(be_n), .ext_address(addr),
        .bank_address(bank), .read_write_dir(dir), .ext_data_in(din), .ext_data_out(dout),
        .ext_data_oe(doe), .async_output_enable_n(oe_n), .async_write_enable_n(we_n),
        .async_ready_in(rdy));
    amem_mem_model amem_mem_model_i (.chip_select_n(cs_n), .mem_clock_out(mck),
        .ext_address(addr), .ext_data_out(dout), .async_output_enable_n(oe_n),
        .async_write_enable_n(we_n), .ready_polarity(pol), .stall, .ext_data_in(din),
        .async_ready_in(rdy), .wr_addr, .wr_data);

    function automatic logic [63:0] pat(input logic [19:0] a);
        return {a, a, a, 4'ha};
    endfunction

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic access(input logic wr, input logic [1:0] rg, input logic [19:0] a,
                          input logic [63:0] d, output logic [63:0] q);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_region <= rg;
        req_addr <= a;
        req_bank <= a[1:0];
        req_be_n <= a[7:0];
        req_wdata <= d;
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        check("completion", {63'h0, rsp_valid}, 64'h1);
        q = rsp_rdata;
    endtask

    task automatic t_rw;
        logic [63:0] q;
        logic [19:0] a;
        for (int r = 0; r < 4; r++) begin
            a = 20'h5a000 ^ 20'(r * 4097);
            access(1'b1, 2'(r), a, {a, ~a, 24'h3c0f0f}, q);
            check("written address", {44'h0, wr_addr}, {44'h0, a});
            check("written data", wr_data, {a, ~a, 24'h3c0f0f});
            access(1'b0, 2'(r), a, 64'h0, q);
            check("read data", q, pat(a));
            check("selects released", {60'h0, cs_n}, 64'hf);
            check("direction idle", {63'h0, dir}, 64'h1);
            check("byte enables", {54'h0, be_n, bank}, {54'h0, a[7:0], a[1:0]});
        end
    endtask

    task automatic t_stall;
        logic [63:0] q;
        int n;
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            pol <= p[0];
            stall <= 1'b1;
            fork
                access(1'b0, 2'h1, 20'h0a5c3, 64'h0, q);
                begin
                    n = 0;
                    while (oe_n !== 1'b0 && n < 400) begin
                        @(negedge mck);
                        n++;
                    end
                    repeat (12) @(negedge mck);
                    check("strobe stretched", {63'h0, oe_n}, 64'h0);
                    @(posedge clk);
                    stall <= 1'b0;
                    n = 0;
                    while (oe_n !== 1'b1 && n < 4) begin
                        @(negedge mck);
                        n++;
                    end
                    check("hold after ready", {63'h0, oe_n}, 64'h1);
                end
            join
            check("stalled read data", q, pat(20'h0a5c3));
        end
    endtask

    task automatic t_src;
        logic [63:0] q;
        time t0;
        @(posedge clk);
        src_sel <= 1'b1;
        repeat (8) @(posedge mck);
        t0 = $time;
        @(posedge mck);
        check("forwarded period", 64'($time - t0), 64'h10);
        access(1'b0, 2'h3, 20'hfffff, 64'h0, q);
        check("fast read data", q, pat(20'hfffff));
    endtask

    initial begin
        for (int r = 0; r < 4; r++) begin
            rs[r] = 4'(r);
            ws[r] = 4'(r + 1);
            rt[r] = 6'(r + 2);
            wt[r] = 6'(r + 2);
            rh[r] = 3'(r + 1);
            wh[r] = 3'(r + 1);
        end
        repeat (3) @(posedge ext_clock_in);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_rw();
        t_stall();
        t_src();
        tally_and_finish();
    end

    initial begin
        #300000;
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
